// ==== hdl/cbs_branch_unit.sv ====
// conditional skip and relative branch unit between decoder and program counter
//
// Functional notes
// - a skip on a set bit of a general register advances the pc by two or three, in 1 to 3 cycles.
// - a skip on a clear i/o register bit advances the pc by two or three, else by one.
// - a skip on a set i/o register bit advances the pc by two or three, else by one.
// - a branch on a set status flag loads pc plus offset plus one, in one or two cycles.
// - a branch on a clear status flag loads pc plus offset plus one, in one or two cycles.
// - branch-equal jumps to pc plus offset plus one only when zero is set.
// - branch-not-equal jumps to pc plus offset plus one only when zero is clear.
// - branch-carry-set jumps when carry is set, and branch-lower uses the same test.
// - branch-carry-clear jumps when carry is clear, else falls through.
// - branch-same-or-higher is taken exactly when carry is clear, like carry-clear.
// - branch-lower is taken exactly when carry is set, target pc plus offset plus one.
// - branch-minus jumps when negative is set, one cycle if not taken, two if taken.
// - branch-plus jumps when negative is clear, else continues.
// - none of these instructions changes any status flag.
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_branch_unit #(
    parameter int PC_W = 16
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_ce,
    input  wire logic                     i_issue,
    input  wire cbs_pkg::cbs_req_t        i_req,
    input  wire logic [PC_W-1:0]          i_pc,
    input  wire logic [7:0]               i_flags,
    input  wire cbs_pkg::cbs_bus_t        i_bus,
    output logic      [`CBS_DATA_W-1:0]   o_rdata,
    output logic                          o_busy,
    output logic                          o_pc_we,
    output logic      [PC_W-1:0]          o_pc_val,
    output logic                          o_taken,
    output logic                          o_flags_we
);
    import cbs_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        cbs_phase_t               phase;
        logic                     pc_we;
        logic [PC_W-1:0]          pc_val;
        logic                     last_taken;
        logic                     last_skip;
        logic                     refused;
        logic                     en;
        logic [7:0]               taken_cnt;
        logic [PC_W-1:0]          last_pc;
        logic [`CBS_DATA_W-1:0]   rdata;
    } cbs_state_t;

    localparam cbs_state_t ST_RST = '{
        phase:      PH_IDLE,
        pc_we:      1'b0,
        pc_val:     '0,
        last_taken: 1'b0,
        last_skip:  1'b0,
        refused:    1'b0,
        en:         `CBS_CTRL_EN_RST,
        taken_cnt:  `CBS_CNT_RST,
        last_pc:    '0,
        rdata:      '0
    };

    cbs_state_t st_ff;
    cbs_state_t nxt_st;

    // ------------------------------------------------------------------------
    // condition and target computation
    // ------------------------------------------------------------------------
    logic                 cond_taken;
    logic                 cond_skip;
    logic [PC_W-1:0]      ofs_ext;
    logic [PC_W-1:0]      skip_inc;
    logic [PC_W-1:0]      branch_tgt;
    logic [PC_W-1:0]      seq_tgt;
    logic                 accept;
    logic                 is_branch;

    cbs_cond_eval u_cond (
        .i_req     (i_req),
        .i_flags   (i_flags),
        .o_taken   (cond_taken),
        .o_is_skip (cond_skip)
    );

    // sign-extend the relative offset to the pc width
    assign ofs_ext = {{(PC_W-`CBS_OFS_W){i_req.ofs[`CBS_OFS_W-1]}}, i_req.ofs};

    // extra words to step over: 0 not taken, 1 over a one-word, 2 over a two-word
    always_comb begin
        skip_inc = '0;
        if (cond_skip && cond_taken) begin
            if (i_req.next_two_word) begin
                skip_inc = PC_W'(2);
            end else begin
                skip_inc = PC_W'(1);
            end
        end
    end

    // pc + k + 1
    cbs_pc_adder #(
        .W (PC_W)
    ) u_branch_add (
        .i_a   (i_pc),
        .i_b   (ofs_ext),
        .i_cin (1'b1),
        .o_sum (branch_tgt)
    );

    // pc + 1, pc + 2 or pc + 3
    cbs_pc_adder #(
        .W (PC_W)
    ) u_seq_add (
        .i_a   (i_pc),
        .i_b   (skip_inc),
        .i_cin (1'b1),
        .o_sum (seq_tgt)
    );

    assign is_branch = (i_req.op != OP_NONE) && !cond_skip;
    assign accept    = i_issue && (st_ff.phase == PH_IDLE) && st_ff.en
                       && (i_req.op != OP_NONE);

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.pc_we = 1'b0;
        nxt_st.rdata = '0;

        // instruction sequencing
        case (st_ff.phase)
            PH_IDLE: begin
                if (accept) begin
                    nxt_st.pc_we      = 1'b1;
                    nxt_st.last_taken = cond_taken;
                    nxt_st.last_skip  = cond_skip;
                    if (is_branch && cond_taken) begin
                        nxt_st.pc_val = branch_tgt;
                        nxt_st.phase  = PH_WAIT1;
                    end else if (cond_skip && cond_taken && i_req.next_two_word) begin
                        nxt_st.pc_val = seq_tgt;
                        nxt_st.phase  = PH_WAIT2;
                    end else if (cond_skip && cond_taken) begin
                        nxt_st.pc_val = seq_tgt;
                        nxt_st.phase  = PH_WAIT1;
                    end else begin
                        nxt_st.pc_val = seq_tgt;
                        nxt_st.phase  = PH_IDLE;
                    end
                    if (is_branch && cond_taken) begin
                        nxt_st.last_pc = branch_tgt;
                    end else begin
                        nxt_st.last_pc = seq_tgt;
                    end
                end
            end
            PH_WAIT2: begin
                nxt_st.phase = PH_WAIT1;
            end
            PH_WAIT1: begin
                nxt_st.phase = PH_IDLE;
            end
            default: begin
                nxt_st.phase = PH_IDLE;
            end
        endcase

        // issue that arrives while busy or disabled is dropped and flagged
        if (i_bus.we && (i_bus.addr == `CBS_ADDR_STAT)
            && i_bus.wdata[`CBS_STAT_REFUSE_BIT]) begin
            nxt_st.refused = 1'b0;
        end
        if (i_issue && !accept) begin
            nxt_st.refused = 1'b1;
        end

        // taken counter: clear from software, an increment in the same cycle leaves it at one
        if (i_bus.we && (i_bus.addr == `CBS_ADDR_CTRL)
            && i_bus.wdata[`CBS_CTRL_CLR_BIT]) begin
            nxt_st.taken_cnt = `CBS_CNT_RST;
        end
        if (accept && cond_taken) begin
            if (i_bus.we && (i_bus.addr == `CBS_ADDR_CTRL)
                && i_bus.wdata[`CBS_CTRL_CLR_BIT]) begin
                nxt_st.taken_cnt = 8'h01;
            end else begin
                nxt_st.taken_cnt = st_ff.taken_cnt + 8'h01;
            end
        end

        // register writes
        if (i_bus.we && (i_bus.addr == `CBS_ADDR_CTRL)) begin
            nxt_st.en = i_bus.wdata[`CBS_CTRL_EN_BIT];
        end

        // register reads, answered in the next cycle
        if (i_bus.re) begin
            case (i_bus.addr)
                `CBS_ADDR_CTRL: begin
                    nxt_st.rdata                   = '0;
                    nxt_st.rdata[`CBS_CTRL_EN_BIT] = st_ff.en;
                end
                `CBS_ADDR_STAT: begin
                    nxt_st.rdata                       = '0;
                    nxt_st.rdata[`CBS_STAT_BUSY_BIT]   = (st_ff.phase != PH_IDLE);
                    nxt_st.rdata[`CBS_STAT_TAKEN_BIT]  = st_ff.last_taken;
                    nxt_st.rdata[`CBS_STAT_SKIP_BIT]   = st_ff.last_skip;
                    nxt_st.rdata[`CBS_STAT_REFUSE_BIT] = st_ff.refused;
                end
                `CBS_ADDR_CNT: begin
                    nxt_st.rdata = st_ff.taken_cnt;
                end
                `CBS_ADDR_PC_LO: begin
                    nxt_st.rdata = st_ff.last_pc[7:0];
                end
                `CBS_ADDR_PC_HI: begin
                    nxt_st.rdata = 8'(st_ff.last_pc >> 8);
                end
                default: begin
                    nxt_st.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= ST_RST;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign o_busy    = (st_ff.phase != PH_IDLE);
    assign o_pc_we   = st_ff.pc_we;
    assign o_pc_val  = st_ff.pc_val;
    assign o_taken   = st_ff.last_taken;
    assign o_rdata   = st_ff.rdata;
    // status flags are never written by this unit
    assign o_flags_we = 1'b0;

endmodule : cbs_branch_unit

// ==== hdl/cbs_cond_eval.sv ====
// condition evaluation for skip and conditional branch instructions
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_cond_eval (
    input  wire cbs_pkg::cbs_req_t i_req,
    input  wire logic [7:0]        i_flags,
    output logic                   o_taken,
    output logic                   o_is_skip
);
    import cbs_pkg::*;

    always_comb begin
        o_taken   = 1'b0;
        o_is_skip = 1'b0;
        case (i_req.op)
            SKIP_REG_BIT_SET: begin
                o_is_skip = 1'b1;
                o_taken   = i_req.reg_val[i_req.bit_sel];
            end
            SKIP_IO_BIT_CLEAR: begin
                o_is_skip = 1'b1;
                o_taken   = ~i_req.io_val[i_req.bit_sel];
            end
            SKIP_IO_BIT_SET: begin
                o_is_skip = 1'b1;
                o_taken   = i_req.io_val[i_req.bit_sel];
            end
            BRANCH_FLAG_SET:       o_taken = i_flags[i_req.flag_sel];
            BRANCH_FLAG_CLEAR:     o_taken = ~i_flags[i_req.flag_sel];
            BRANCH_EQUAL:          o_taken = i_flags[`CBS_FLAG_Z];
            BRANCH_NOT_EQUAL:      o_taken = ~i_flags[`CBS_FLAG_Z];
            BRANCH_CARRY_SET:      o_taken = i_flags[`CBS_FLAG_C];
            BRANCH_LOWER:          o_taken = i_flags[`CBS_FLAG_C];
            BRANCH_CARRY_CLEAR:    o_taken = ~i_flags[`CBS_FLAG_C];
            BRANCH_SAME_OR_HIGHER: o_taken = ~i_flags[`CBS_FLAG_C];
            BRANCH_MINUS:          o_taken = i_flags[`CBS_FLAG_N];
            BRANCH_PLUS:           o_taken = ~i_flags[`CBS_FLAG_N];
            default: begin
                o_taken   = 1'b0;
                o_is_skip = 1'b0;
            end
        endcase
    end

endmodule : cbs_cond_eval

// ==== hdl/cbs_pc_adder.sv ====
// program counter adder with carry-in
`timescale 1ns/1ps
module cbs_pc_adder #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] i_a,
    input  wire logic [W-1:0] i_b,
    input  wire logic         i_cin,
    output logic      [W-1:0] o_sum
);
    import cbs_pkg::*;

    assign o_sum = i_a + i_b + {{(W-1){1'b0}}, i_cin};

endmodule : cbs_pc_adder

// ==== inc/cbs_pkg.sv ====
// types shared by the branch/skip unit
package cbs_pkg;
`include "cbs_regs.svh"

    typedef enum logic [3:0] {
        OP_NONE,
        SKIP_REG_BIT_SET,
        SKIP_IO_BIT_CLEAR,
        SKIP_IO_BIT_SET,
        BRANCH_FLAG_SET,
        BRANCH_FLAG_CLEAR,
        BRANCH_EQUAL,
        BRANCH_NOT_EQUAL,
        BRANCH_CARRY_SET,
        BRANCH_CARRY_CLEAR,
        BRANCH_SAME_OR_HIGHER,
        BRANCH_LOWER,
        BRANCH_MINUS,
        BRANCH_PLUS
    } cbs_op_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WAIT2,
        PH_WAIT1
    } cbs_phase_t;

    typedef struct packed {
        cbs_op_t                 op;
        logic [2:0]              bit_sel;
        logic [2:0]              flag_sel;
        logic [`CBS_OFS_W-1:0]   ofs;
        logic                    next_two_word;
        logic [7:0]              reg_val;
        logic [7:0]              io_val;
    } cbs_req_t;

    typedef struct packed {
        logic                    we;
        logic                    re;
        logic [`CBS_ADDR_W-1:0]  addr;
        logic [`CBS_DATA_W-1:0]  wdata;
    } cbs_bus_t;

endpackage : cbs_pkg

// ==== inc/cbs_regs.svh ====
// register offsets, field positions, reset values and cycle counts of the branch/skip unit
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define CBS_OFS_W           7
`define CBS_ADDR_W          8
`define CBS_DATA_W          8

// ----------------------------------------------------------------------------
// status register flag positions
// ----------------------------------------------------------------------------
`define CBS_FLAG_C          0
`define CBS_FLAG_Z          1
`define CBS_FLAG_N          2

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CBS_ADDR_CTRL       8'h00
`define CBS_ADDR_STAT       8'h01
`define CBS_ADDR_CNT        8'h02
`define CBS_ADDR_PC_LO      8'h03
`define CBS_ADDR_PC_HI      8'h04

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define CBS_CTRL_EN_BIT     0
`define CBS_CTRL_CLR_BIT    1
`define CBS_CTRL_EN_RST     1'b1
`define CBS_STAT_BUSY_BIT   0
`define CBS_STAT_TAKEN_BIT  1
`define CBS_STAT_SKIP_BIT   2
`define CBS_STAT_REFUSE_BIT 3
`define CBS_CNT_RST         8'h00

// ----------------------------------------------------------------------------
// cycle counts per instruction
// ----------------------------------------------------------------------------
`define CBS_CYC_NOT_TAKEN   1
`define CBS_CYC_BR_TAKEN    2
`define CBS_CYC_SKIP_ONE    2
`define CBS_CYC_SKIP_TWO    3

`endif

// ==== verification/cbs_branch_unit_properties.sv ====
// port assertions of the branch/skip unit
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_branch_unit_properties
    import cbs_pkg::*;
#(
    parameter int PC_W = 16
) (
    input wire logic                   i_clk,
    input wire logic                   i_rst,
    input wire logic                   i_ce,
    input wire logic                   i_issue,
    input wire cbs_pkg::cbs_req_t      i_req,
    input wire logic [PC_W-1:0]        i_pc,
    input wire logic [7:0]             i_flags,
    input wire cbs_pkg::cbs_bus_t      i_bus,
    input wire logic [`CBS_DATA_W-1:0] o_rdata,
    input wire logic                   o_busy,
    input wire logic                   o_pc_we,
    input wire logic [PC_W-1:0]        o_pc_val,
    input wire logic                   o_taken,
    input wire logic                   o_flags_we
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic            en_ff;
    logic            acc;
    logic            tk;
    logic            skp;
    logic [PC_W-1:0] inc;
    logic [PC_W-1:0] tgt;

    function automatic logic cond_of(input cbs_req_t r, input logic [7:0] s);
        case (r.op)
            SKIP_REG_BIT_SET, SKIP_IO_BIT_SET: return r.op == SKIP_REG_BIT_SET ?
                r.reg_val[r.bit_sel] : r.io_val[r.bit_sel];
            SKIP_IO_BIT_CLEAR: return !r.io_val[r.bit_sel];
            BRANCH_FLAG_SET: return s[r.flag_sel];
            BRANCH_FLAG_CLEAR: return !s[r.flag_sel];
            BRANCH_EQUAL: return s[`CBS_FLAG_Z];
            BRANCH_NOT_EQUAL: return !s[`CBS_FLAG_Z];
            BRANCH_CARRY_SET, BRANCH_LOWER: return s[`CBS_FLAG_C];
            BRANCH_CARRY_CLEAR, BRANCH_SAME_OR_HIGHER: return !s[`CBS_FLAG_C];
            BRANCH_MINUS: return s[`CBS_FLAG_N];
            BRANCH_PLUS: return !s[`CBS_FLAG_N];
            default: return 1'b0;
        endcase
    endfunction : cond_of

    // enable bit mirrored from bus writes, since acceptance depends on it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            en_ff <= `CBS_CTRL_EN_RST;
        end else if (i_ce && i_bus.we && i_bus.addr == `CBS_ADDR_CTRL) begin
            en_ff <= i_bus.wdata[`CBS_CTRL_EN_BIT];
        end
    end

    assign acc = i_ce && i_issue && !o_busy && en_ff && i_req.op != OP_NONE;
    assign tk  = cond_of(i_req, i_flags);
    assign skp = i_req.op inside {SKIP_REG_BIT_SET, SKIP_IO_BIT_CLEAR, SKIP_IO_BIT_SET};
    assign inc = !tk ? PC_W'(1) : skp ? PC_W'(i_req.next_two_word ? 3 : 2)
               : PC_W'(signed'(i_req.ofs)) + PC_W'(1);
    assign tgt = i_pc + inc;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_busy_one;
        o_busy ##1 !o_busy;
    endsequence
    sequence s_busy_two;
        o_busy [*2] ##1 !o_busy;
    endsequence

    a_skip_target: assert property (
        acc && skp |=> o_pc_we && o_pc_val == $past(tgt) && o_taken == $past(tk))
        else $error("skip answer wrong");
    a_branch_target: assert property (
        acc && !skp |=> o_pc_we && o_pc_val == $past(tgt) && o_taken == $past(tk))
        else $error("branch answer wrong");
    a_busy_branch: assert property (acc && tk && !skp |=> s_busy_one)
        else $error("taken branch length wrong");
    a_busy_skip_one: assert property (
        acc && tk && skp && !i_req.next_two_word |=> s_busy_one)
        else $error("one-word skip length wrong");
    a_busy_skip_two: assert property (
        acc && tk && skp && i_req.next_two_word |=> s_busy_two)
        else $error("two-word skip length wrong");
    a_not_taken_quick: assert property (acc && !tk |=> !o_busy)
        else $error("not-taken instruction busy");
    a_idle_holds: assert property (!acc |=> !o_pc_we && $stable(o_pc_val))
        else $error("pc load without accepted instruction");
    a_no_flag_write: assert property (o_flags_we == 1'b0)
        else $error("status flags written");
endmodule : cbs_branch_unit_properties

// ==== verification/tb.sv ====
// self-checking bench of the branch/skip unit
`timescale 1ns/1ps
`include "cbs_regs.svh"
module tb;
    import cbs_pkg::*;

    typedef struct {
        cbs_op_t    op;
        logic [7:0] sr;
        logic [7:0] val;
        logic [2:0] sel;
        logic [6:0] ofs;
        logic       tw;
        logic       tk;
    } cbs_row_t;

    logic                   i_clk;
    logic                   i_rst;
    logic                   i_ce;
    logic                   i_issue;
    cbs_req_t               i_req;
    logic [15:0]            i_pc;
    logic [7:0]             i_flags;
    cbs_bus_t               i_bus;
    logic [`CBS_DATA_W-1:0] o_rdata;
    logic                   o_busy;
    logic                   o_pc_we;
    logic [15:0]            o_pc_val;
    logic                   o_taken;
    logic                   o_flags_we;
    int                     err_total = 0;
    int                     checks = 0;
    logic [15:0]            last_np;
    cbs_row_t               bad;
    cbs_row_t rows [26] = '{
        '{SKIP_REG_BIT_SET, 8'h00, 8'h80, 7, 7'h00, 0, 1},
        '{SKIP_REG_BIT_SET, 8'h00, 8'h7F, 7, 7'h00, 1, 0},
        '{SKIP_IO_BIT_CLEAR, 8'h00, 8'hFE, 0, 7'h00, 1, 1},
        '{SKIP_IO_BIT_CLEAR, 8'h00, 8'h01, 0, 7'h00, 0, 0},
        '{SKIP_IO_BIT_SET, 8'h00, 8'h10, 4, 7'h00, 1, 1},
        '{SKIP_IO_BIT_SET, 8'h00, 8'hEF, 4, 7'h00, 0, 0},
        '{BRANCH_FLAG_SET, 8'h40, 8'h00, 6, 7'h3F, 0, 1},
        '{BRANCH_FLAG_SET, 8'hBF, 8'h00, 6, 7'h3F, 0, 0},
        '{BRANCH_FLAG_CLEAR, 8'hF7, 8'h00, 3, 7'h40, 0, 1},
        '{BRANCH_FLAG_CLEAR, 8'h08, 8'h00, 3, 7'h40, 0, 0},
        '{BRANCH_EQUAL, 8'h02, 8'h00, 0, 7'h7D, 1, 1},
        '{BRANCH_EQUAL, 8'hFD, 8'h00, 0, 7'h7D, 0, 0},
        '{BRANCH_NOT_EQUAL, 8'hFD, 8'h00, 0, 7'h05, 0, 1},
        '{BRANCH_NOT_EQUAL, 8'h02, 8'h00, 0, 7'h05, 0, 0},
        '{BRANCH_CARRY_SET, 8'h01, 8'h00, 0, 7'h7F, 0, 1},
        '{BRANCH_CARRY_SET, 8'hFE, 8'h00, 0, 7'h7F, 0, 0},
        '{BRANCH_CARRY_CLEAR, 8'hFE, 8'h00, 0, 7'h10, 0, 1},
        '{BRANCH_CARRY_CLEAR, 8'h01, 8'h00, 0, 7'h10, 0, 0},
        '{BRANCH_SAME_OR_HIGHER, 8'hFE, 8'h00, 0, 7'h22, 0, 1},
        '{BRANCH_SAME_OR_HIGHER, 8'hFF, 8'h00, 0, 7'h22, 0, 0},
        '{BRANCH_LOWER, 8'h01, 8'h00, 0, 7'h70, 0, 1},
        '{BRANCH_LOWER, 8'hFE, 8'h00, 0, 7'h70, 0, 0},
        '{BRANCH_MINUS, 8'h04, 8'h00, 0, 7'h01, 0, 1},
        '{BRANCH_MINUS, 8'hFB, 8'h00, 0, 7'h01, 0, 0},
        '{BRANCH_PLUS, 8'hFB, 8'h00, 0, 7'h02, 0, 1},
        '{BRANCH_PLUS, 8'h04, 8'h00, 0, 7'h02, 0, 0}};

    cbs_branch_unit #(.PC_W(16)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_issue(i_issue), .i_req(i_req), .i_pc(i_pc), .i_flags(i_flags), .i_bus(i_bus),
        .o_rdata(o_rdata), .o_busy(o_busy), .o_pc_we(o_pc_we), .o_pc_val(o_pc_val),
        .o_taken(o_taken), .o_flags_we(o_flags_we));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic drive(input cbs_row_t r, input logic [15:0] pc, input logic on);
        i_issue <= on;
        i_req   <= '{r.op, r.sel, r.sel, r.ofs, r.tw, r.val, r.val};
        i_pc    <= pc;
        i_flags <= r.sr;
    endtask : drive

    task automatic run_row(input cbs_row_t r, input logic [15:0] pc);
        logic        skp;
        logic [15:0] np;
        skp = r.op inside {SKIP_REG_BIT_SET, SKIP_IO_BIT_CLEAR, SKIP_IO_BIT_SET};
        np = !r.tk ? pc + 16'h0001 : skp ? pc + 16'h0002 + 16'(r.tw)
           : pc + {{9{r.ofs[6]}}, r.ofs} + 16'h0001;
        @(posedge i_clk);
        drive(r, pc, 1'b1);
        @(posedge i_clk);
        i_issue <= 1'b0;
        #1;
        check(o_pc_we, 1'b1);
        check(o_pc_val, np);
        check(o_taken, r.tk);
        check(o_flags_we, 1'b0);
        repeat (!r.tk ? 0 : skp ? 1 + r.tw : 1) begin
            check(o_busy, 1'b1);
            @(posedge i_clk);
            #1;
        end
        check(o_busy, 1'b0);
        last_np = np;
    endtask : run_row

    task automatic refused(input cbs_row_t r);
        @(posedge i_clk);
        drive(r, 16'h0600, 1'b1);
        @(posedge i_clk);
        i_issue <= 1'b0;
        #1;
        check(o_pc_we, 1'b0);
    endtask : refused

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk);
        i_bus <= '{1'b0, 1'b0, a, d};
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_clk);
        i_bus <= '{1'b0, 1'b0, a, 8'h00};
        #1;
        check(o_rdata, e);
    endtask : bus_rd

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    initial begin
        #4000000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        i_rst   = 1'b1;
        i_ce    = 1'b1;
        i_issue = 1'b0;
        i_req   = '0;
        i_pc    = '0;
        i_flags = '0;
        i_bus   = '0;
        repeat (20) @(posedge i_clk);
        #1;
        check(o_pc_we, 1'b0);
        check(o_pc_val, 16'h0000);
        check(o_busy, 1'b0);
        @(posedge i_clk);
        i_rst <= 1'b0;
        bus_rd(`CBS_ADDR_CNT, 8'h00);
        for (int i = 0; i < 26; i++) begin
            run_row(rows[i], 16'hFFF0 + 16'(i));
        end
        bus_rd(`CBS_ADDR_CNT, 8'h0D);
        bus_rd(`CBS_ADDR_STAT, 8'h00);
        bus_rd(`CBS_ADDR_PC_LO, last_np[7:0]);
        bus_rd(`CBS_ADDR_PC_HI, last_np[15:8]);
        bus_rd(8'h07, 8'h00);
        // two not-taken instructions back to back
        @(posedge i_clk);
        drive(rows[1], 16'h0200, 1'b1);
        @(posedge i_clk);
        drive(rows[3], 16'h0300, 1'b1);
        #1;
        check(o_pc_val, 16'h0201);
        @(posedge i_clk);
        i_issue <= 1'b0;
        #1;
        check(o_pc_we, 1'b1);
        check(o_pc_val, 16'h0301);
        bus_rd(`CBS_ADDR_STAT, 8'h04);
        // issue held into the busy cycle of a taken branch is refused
        @(posedge i_clk);
        drive(rows[10], 16'h0400, 1'b1);
        @(posedge i_clk);
        drive(rows[10], 16'h0500, 1'b1);
        #1;
        check(o_pc_val, 16'h03FE);
        @(posedge i_clk);
        i_issue <= 1'b0;
        #1;
        check(o_pc_we, 1'b0);
        bus_rd(`CBS_ADDR_STAT, 8'h0A);
        bus_wr(`CBS_ADDR_STAT, 8'h08);
        bus_rd(`CBS_ADDR_STAT, 8'h02);
        bus_wr(`CBS_ADDR_CTRL, 8'h00);
        refused(rows[1]);
        bus_wr(`CBS_ADDR_CTRL, 8'h01);
        bad = rows[1];
        bad.op = OP_NONE;
        refused(bad);
        bus_rd(`CBS_ADDR_STAT, 8'h0A);
        bus_rd(`CBS_ADDR_CNT, 8'h0E);
        bus_wr(`CBS_ADDR_CTRL, 8'h03);
        bus_rd(`CBS_ADDR_CNT, 8'h00);
        // reset in mid-run, then work again
        @(posedge i_clk);
        i_rst <= 1'b1;
        @(posedge i_clk);
        #1;
        check(o_pc_val, 16'h0000);
        check(o_taken, 1'b0);
        @(posedge i_clk);
        i_rst <= 1'b0;
        run_row(rows[22], 16'h0010);
        // an instruction offered while the clock enable is low is not taken
        @(posedge i_clk);
        i_ce <= 1'b0;
        drive(rows[0], 16'h0700, 1'b1);
        @(posedge i_clk);
        i_ce    <= 1'b1;
        i_issue <= 1'b0;
        #1;
        check(o_pc_we, 1'b0);
        check(o_pc_val, 16'h0012);
        tally_and_finish();
    end
endmodule : tb

bind cbs_branch_unit cbs_branch_unit_properties #(.PC_W(PC_W)) u_props (.i_clk(i_clk),
    .i_rst(i_rst), .i_ce(i_ce), .i_issue(i_issue), .i_req(i_req), .i_pc(i_pc),
    .i_flags(i_flags), .i_bus(i_bus), .o_rdata(o_rdata), .o_busy(o_busy),
    .o_pc_we(o_pc_we), .o_pc_val(o_pc_val), .o_taken(o_taken), .o_flags_we(o_flags_we));
